// [ecs_pkg.sv]
// package: register map, config layout and timing of the counter status block
package ecs_pkg;

  // clock and timing
  localparam int unsigned CLK_HZ       = 50_000_000;
  localparam int unsigned INIT_TIME_US = 10;
  localparam int unsigned INIT_CYCLES  = INIT_TIME_US * (CLK_HZ / 1_000_000);
  localparam int unsigned ZF_TIME_MS   = 100;
  localparam int unsigned ZF_CYCLES    = ZF_TIME_MS * (CLK_HZ / 1_000);

  // register byte offsets
  localparam logic [7:0] OFF_SNAP     = 8'h00;
  localparam logic [7:0] OFF_LIVE     = 8'h04;
  localparam logic [7:0] OFF_CAPT     = 8'h08;
  localparam logic [7:0] OFF_STATUS   = 8'h0C;
  localparam logic [7:0] OFF_ERRCODE  = 8'h10;
  localparam logic [7:0] OFF_CFG0     = 8'h14;
  localparam logic [7:0] OFF_CFG1     = 8'h18;
  localparam logic [7:0] OFF_ROLLOVER = 8'h1C;
  localparam logic [7:0] OFF_PRESET   = 8'h20;
  localparam logic [7:0] OFF_WIN_ON   = 8'h24;
  localparam logic [7:0] OFF_WIN_OFF  = 8'h28;
  localparam logic [7:0] OFF_OUTCFG   = 8'h2C;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h30;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h34;

  // reset values and rollover limit
  localparam logic [31:0] CFG0_RST     = 32'h0000_7800;
  localparam logic [31:0] ROLLOVER_RST = 32'h00FF_FFFF;
  localparam logic [31:0] ROLLOVER_MAX = 32'h0100_0000;

  // snapshot control bits
  localparam int SNAP_CLR  = 0;
  localparam int SNAP_PRE  = 1;
  localparam int SNAP_VCLR = 2;

  // status word bits
  localparam int ST_ZF    = 1;
  localparam int ST_SCNT  = 2;
  localparam int ST_A     = 4;
  localparam int ST_B     = 5;
  localparam int ST_Z     = 6;
  localparam int ST_NRDY  = 13;
  localparam int ST_NVBAD = 14;
  localparam int ST_PFLT  = 15;

  // error code bits
  localparam int ERR_RSVD = 0;
  localparam int ERR_FILT = 1;
  localparam int ERR_TB   = 2;
  localparam int ERR_GATE = 3;
  localparam int ERR_ROLL = 4;
  localparam int ERR_PRE  = 5;
  localparam int ERR_SCAL = 6;
  localparam int ERR_TIE  = 7;
  localparam int ERR_WIN  = 8;
  localparam int ERR_DP   = 9;
  localparam int ERR_ASM  = 10;

  // check limits
  localparam logic [15:0] TB_STEP  = 16'h000A;
  localparam logic [15:0] TB_MAX   = 16'h0BB8;
  localparam logic [7:0]  GATE_MAX = 8'hC8;
  localparam logic [23:0] GATE_MS  = 24'h000BB8;
  localparam logic [7:0]  ASM_A    = 8'h69;
  localparam logic [7:0]  ASM_B    = 8'h6A;
  localparam logic signed [7:0] DP_MIN = -8'sd4;
  localparam logic signed [7:0] DP_MAX = 8'sd2;

  // counter configuration codes
  localparam logic [3:0] CC_COUNT  = 4'h0;
  localparam logic [3:0] CC_ENC_X1 = 4'h1;
  localparam logic [3:0] CC_ENC_X2 = 4'h2;
  localparam logic [3:0] CC_ENC_X4 = 4'h4;
  localparam logic [3:0] CC_PERIOD = 4'h5;
  localparam logic [3:0] CC_RATE   = 4'h7;
  localparam logic [2:0] SM_MAX    = 3'h4;

  // interrupt event bits
  localparam int EV_STORE = 0;
  localparam int EV_FAULT = 1;
  localparam int EV_ZF    = 2;
  localparam int EV_W     = 3;

  typedef struct packed {
    logic [7:0]  cnt_cfg;
    logic [7:0]  filt;
    logic [7:0]  dec_pos;
    logic [7:0]  gate;
    logic [15:0] time_base;
    logic [7:0]  scalar;
    logic [7:0]  assembly;
    logic [31:0] rollover;
    logic [31:0] preset;
    logic [31:0] win_on;
    logic [31:0] win_off;
    logic        pwm_sel;
    logic        tie_en;
  } ecs_cfg_t;

  typedef struct packed {
    logic nv_bad;
    logic z;
    logic b;
    logic a;
  } ecs_pins_t;

endpackage

// [ecs_cfg_check.sv]
// configuration validation: builds the error code word from the config set
`timescale 1ns/1ps
module ecs_cfg_check import ecs_pkg::*; (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // configuration set
  input  wire ecs_cfg_t    cfg,
  // error code word
  output logic      [15:0] err_code
);
  logic [15:0] next_err;
  logic [3:0]  cc;
  logic [2:0]  sm;
  logic [23:0] tb_prod;
  logic signed [7:0] dp;

  // combinational checks, registered once to keep timing short
  always_comb begin
    cc       = cfg.cnt_cfg[3:0];
    sm       = cfg.cnt_cfg[6:4];
    dp       = $signed(cfg.dec_pos);
    tb_prod  = 24'(cfg.time_base) * 24'(cfg.gate);
    next_err = 16'h0000;
    next_err[ERR_ASM] = !(cfg.assembly == 8'h00 ||
                          cfg.assembly == ASM_A ||
                          cfg.assembly == ASM_B);
    next_err[ERR_DP]  = (cc == CC_PERIOD || cc == CC_RATE) &&
                        (dp < DP_MIN || dp > DP_MAX);
    next_err[ERR_WIN] = (cfg.win_on == cfg.win_off &&
                         cfg.win_on != 32'h0) ||
                        cfg.win_on > cfg.rollover ||
                        cfg.win_off > cfg.rollover;
    next_err[ERR_TIE] = cfg.tie_en && cfg.win_on == 32'h0 &&
                        cfg.win_off == 32'h0;
    // scalar read as unsigned byte, one-hot power of two
    next_err[ERR_SCAL] = (cc == CC_PERIOD) &&
                         ($countones(cfg.scalar) != 1);
    next_err[ERR_PRE] = cfg.preset >= cfg.rollover;
    next_err[ERR_ROLL] = (cfg.rollover == 32'h0 && !cfg.pwm_sel) ||
                         (cfg.rollover != 32'h0 && cfg.pwm_sel) ||
                         cfg.rollover > ROLLOVER_MAX;
    next_err[ERR_GATE] = (cc == CC_RATE) &&
                         (cfg.gate == 8'h00 || cfg.gate > GATE_MAX ||
                          tb_prod > GATE_MS);
    next_err[ERR_TB]  = (cfg.time_base % TB_STEP) != 16'h0 ||
                        cfg.time_base > TB_MAX;
    next_err[ERR_FILT] = (cfg.filt[6:4] != 3'b000 &&
                          cfg.filt[3:0] == 4'h0) ||
                         $countones(cfg.filt[3:0]) > 1;
    next_err[ERR_RSVD] = !(cc == CC_COUNT || cc == CC_ENC_X1 ||
                           cc == CC_ENC_X2 || cc == CC_ENC_X4 ||
                           cc == CC_PERIOD || cc == CC_RATE) ||
                         sm > SM_MAX;
  end

  // error word register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      err_code <= 16'h0000;
    end else begin
      err_code <= next_err;
    end
  end

endmodule // ecs_cfg_check

// [ecs_top.sv]
// encoder counter status, config checks and AXI4-Lite register slave
//
// Overview of operation
// - snapshot bits 0,1,2 clear count, load preset, clear stored count.
// - status bits 4,5,6 follow inputs A, B and Z.
// - bad config sets status bit 15 and writes an error code word.
// - while a config fault stands the counter stays out of operation.
// - stored count is a full 32-bit unsigned value.
// - error bit 10 flags an assembly other than 0, 105 or 106.
// - error bit 9 flags decimal position out of range.
// - error bit 8 flags bad window on and off values.
// - error bit 7 flags a tie to an unprogrammed window.
// - error bit 6 flags missing or multiple scalar selections.
// - error bit 5 flags preset not below rollover.
// - error bit 4 flags rollover zero, conflicting with PWM, or too large.
// - error bit 3 flags gate interval missing, above 200, or too long.
// - error bit 2 flags time base not multiple of 10 or above 3000.
// - error bit 1 flags filter enabled without, or with many, frequencies.
// - error bit 0 flags reserved counter config or mode codes.
`timescale 1ns/1ps
module ecs_top import ecs_pkg::*; #(
  parameter int unsigned ZF_CYC = ZF_CYCLES
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // axi4-lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // encoder pins and config memory check
  input  wire ecs_pins_t   pins,
  // interrupt
  output logic             irq
);
  ecs_cfg_t    cfg;
  ecs_pins_t   pin_s1;
  ecs_pins_t   pin_s2;
  ecs_pins_t   pin_d;
  logic [31:0] cfg0;
  logic [31:0] cfg1;
  logic [31:0] rollover;
  logic [31:0] preset;
  logic [31:0] win_on;
  logic [31:0] win_off;
  logic [1:0]  outcfg;
  logic [7:0]  snap;
  logic [31:0] live_cnt;
  logic [31:0] capt_cnt;
  logic [1:0]  store_cnt;
  logic [15:0] err_code;
  logic [15:0] status;
  logic [31:0] zf_timer;
  logic        zf_flag;
  logic [15:0] init_timer;
  logic        not_ready;
  logic        nv_bad;
  logic        fault;
  logic        fault_d;
  logic        zf_d;
  logic        run;
  logic        a_rise;
  logic        z_rise;
  logic        count_dir_dn;
  logic        store_ev;
  logic [EV_W-1:0] irq_stat;
  logic [EV_W-1:0] irq_mask;
  logic [EV_W-1:0] ev;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        aw_full;
  logic        w_full;
  logic        wr_fire;
  logic        wr_ok;
  logic [31:0] rd_mux;
  logic        rd_ok;
  logic [7:0]  ar_word;
  logic [7:0]  aw_word;

  // byte-lane merge for writable words
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction

  // configuration view for the checker
  assign cfg = '{cnt_cfg: cfg0[7:0], filt: cfg0[15:8],
                 dec_pos: cfg0[23:16], gate: cfg0[31:24],
                 time_base: cfg1[15:0], scalar: cfg1[23:16],
                 assembly: cfg1[31:24], rollover: rollover,
                 preset: preset, win_on: win_on, win_off: win_off,
                 pwm_sel: outcfg[0], tie_en: outcfg[1]};

  ecs_cfg_check u_check (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .cfg      (cfg),
    .err_code (err_code)
  );

  // pins are asynchronous: two stages, then an edge history stage
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_d  <= '0;
    end else begin
      pin_s1 <= pins;
      pin_s2 <= pin_s1;
      pin_d  <= pin_s2;
    end
  end

  // edges; z polarity follows config bit 7
  assign a_rise = pin_s2.a && !pin_d.a;
  assign z_rise = (pin_s2.z ^ cfg0[7]) && !(pin_d.z ^ cfg0[7]);
  assign count_dir_dn = (cfg0[3:0] != CC_COUNT) && pin_s2.b;
  assign fault    = err_code != 16'h0000;
  assign run      = !not_ready && !fault;
  assign store_ev = run && z_rise && (cfg0[6:4] != 3'h0);

  // power-up initialisation window and latched config memory fault
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      init_timer <= 16'h0000;
      not_ready  <= 1'b1;
      nv_bad     <= 1'b0;
    end else begin
      if (not_ready) begin
        init_timer <= init_timer + 16'h0001;
        if (init_timer == 16'(INIT_CYCLES - 1)) begin
          not_ready <= 1'b0;
        end
      end
      if (pin_s2.nv_bad) begin
        nv_bad <= 1'b1;
      end
    end
  end

  // live count; snapshot bits act as levels while held at one
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      live_cnt <= 32'h0000_0000;
    end else if (snap[SNAP_CLR]) begin
      live_cnt <= 32'h0000_0000;
    end else if (snap[SNAP_PRE]) begin
      live_cnt <= preset;
    end else if (store_ev && cfg0[6:4] >= 3'h3) begin
      live_cnt <= 32'h0000_0000;
    end else if (run && a_rise) begin
      // rollover of zero runs free; only legal with pwm selected
      if (count_dir_dn) begin
        live_cnt <= (live_cnt == 32'h0) ? rollover - 32'h1
                                        : live_cnt - 32'h1;
      end else if (rollover != 32'h0 && live_cnt >= rollover - 32'h1) begin
        live_cnt <= 32'h0000_0000;
      end else begin
        live_cnt <= live_cnt + 32'h1;
      end
    end
  end

  // stored count and its update counter
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      capt_cnt  <= 32'h0000_0000;
      store_cnt <= 2'h0;
    end else begin
      if (snap[SNAP_VCLR]) begin
        capt_cnt <= 32'h0000_0000;
      end else if (store_ev) begin
        capt_cnt <= live_cnt;
      end
      if (store_ev) begin
        store_cnt <= store_cnt + 2'h1;
      end
    end
  end

  // zero-frequency watch on input a
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      zf_timer <= 32'h0000_0000;
      zf_flag  <= 1'b0;
    end else if (a_rise) begin
      zf_timer <= 32'h0000_0000;
      zf_flag  <= 1'b0;
    end else if (zf_timer == 32'(ZF_CYC - 1)) begin
      zf_flag  <= 1'b1;
    end else begin
      zf_timer <= zf_timer + 32'h1;
    end
  end

  // status word
  always_comb begin
    status           = 16'h0000;
    status[ST_ZF]    = zf_flag;
    status[ST_SCNT +: 2] = store_cnt;
    status[ST_A]     = pin_s2.a;
    status[ST_B]     = pin_s2.b;
    status[ST_Z]     = pin_s2.z;
    status[ST_NRDY]  = not_ready;
    status[ST_NVBAD] = nv_bad;
    status[ST_PFLT]  = fault;
  end

  // interrupt events: rising fault, rising zero frequency, store
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      fault_d <= 1'b0;
      zf_d    <= 1'b0;
    end else begin
      fault_d <= fault;
      zf_d    <= zf_flag;
    end
  end

  always_comb begin
    ev           = '0;
    ev[EV_STORE] = store_ev;
    ev[EV_FAULT] = fault && !fault_d;
    ev[EV_ZF]    = zf_flag && !zf_d;
  end

  // sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq_stat <= '0;
      irq      <= 1'b0;
    end else begin
      if (wr_fire && aw_word == OFF_IRQ_STAT && w_strb[0]) begin
        irq_stat <= (irq_stat & ~w_data[EV_W-1:0]) | ev;
      end else begin
        irq_stat <= irq_stat | ev;
      end
      irq <= |(irq_stat & irq_mask);
    end
  end

  // axi write side: address and data taken in either order
  assign aw_word = {aw_addr[7:2], 2'b00};
  assign wr_fire = aw_full && w_full && !s_axi_bvalid;
  always_comb begin
    case (aw_word)
      OFF_SNAP, OFF_CFG0, OFF_CFG1, OFF_ROLLOVER, OFF_PRESET,
      OFF_WIN_ON, OFF_WIN_OFF, OFF_OUTCFG, OFF_IRQ_STAT,
      OFF_IRQ_MASK: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
      aw_full       <= 1'b0;
      w_full        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0;
      w_strb        <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr       <= s_axi_awaddr;
        aw_full       <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        w_full       <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_full      <= 1'b0;
        w_full       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? 2'b00 : 2'b10;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // writable registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      snap     <= 8'h00;
      cfg0     <= CFG0_RST;
      cfg1     <= 32'h0;
      rollover <= ROLLOVER_RST;
      preset   <= 32'h0;
      win_on   <= 32'h0;
      win_off  <= 32'h0;
      outcfg   <= 2'h0;
      irq_mask <= '0;
    end else if (wr_fire) begin
      case (aw_word)
        OFF_SNAP:     snap     <= w_strb[0] ? w_data[7:0] : snap;
        OFF_CFG0:     cfg0     <= merge(cfg0, w_data, w_strb);
        OFF_CFG1:     cfg1     <= merge(cfg1, w_data, w_strb);
        OFF_ROLLOVER: rollover <= merge(rollover, w_data, w_strb);
        OFF_PRESET:   preset   <= merge(preset, w_data, w_strb);
        OFF_WIN_ON:   win_on   <= merge(win_on, w_data, w_strb);
        OFF_WIN_OFF:  win_off  <= merge(win_off, w_data, w_strb);
        OFF_OUTCFG:   outcfg   <= w_strb[0] ? w_data[1:0] : outcfg;
        OFF_IRQ_MASK: irq_mask <= w_strb[0] ? w_data[EV_W-1:0] : irq_mask;
        default: ;
      endcase
    end
  end

  // read mux; unmapped words answer slverr with zero data
  assign ar_word = {s_axi_araddr[7:2], 2'b00};
  always_comb begin
    rd_ok  = 1'b1;
    rd_mux = 32'h0;
    case (ar_word)
      OFF_SNAP:     rd_mux = {24'h0, snap};
      OFF_LIVE:     rd_mux = live_cnt;
      OFF_CAPT:     rd_mux = capt_cnt;
      OFF_STATUS:   rd_mux = {16'h0, status};
      OFF_ERRCODE:  rd_mux = {16'h0, err_code};
      OFF_CFG0:     rd_mux = cfg0;
      OFF_CFG1:     rd_mux = cfg1;
      OFF_ROLLOVER: rd_mux = rollover;
      OFF_PRESET:   rd_mux = preset;
      OFF_WIN_ON:   rd_mux = win_on;
      OFF_WIN_OFF:  rd_mux = win_off;
      OFF_OUTCFG:   rd_mux = {30'h0, outcfg};
      OFF_IRQ_STAT: rd_mux = {29'h0, irq_stat};
      OFF_IRQ_MASK: rd_mux = {29'h0, irq_mask};
      default:      rd_ok  = 1'b0;
    endcase
  end

  // axi read side, one read under way at a time
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= 2'b00;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_mux;
        s_axi_rresp   <= rd_ok ? 2'b00 : 2'b10;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // ecs_top

// [ecs_checker.sv]
// concurrent checks on the port side of the counter status block
`timescale 1ns/1ps
module ecs_checker import ecs_pkg::*; #(
  parameter int unsigned ZF_CYC = ZF_CYCLES
) (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        rst,
  // write channels
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  // read channels
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // encoder pins
  input wire ecs_pins_t   pins
);
  logic [2:0] pin_lvl;
  // z, b, a in status bit order
  assign pin_lvl = {pins.z, pins.b, pins.a};
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // both write channels taken at one edge
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // read of one given word taken
  sequence s_rd_take(a);
    s_axi_arvalid && s_axi_arready && s_axi_araddr == a;
  endsequence
  // pins still long enough to pass the synchronisers
  sequence s_pins_quiet;
    pin_lvl == $past(pin_lvl) && pin_lvl == $past(pin_lvl, 2)
      && pin_lvl == $past(pin_lvl, 3) && pin_lvl == $past(pin_lvl, 4);
  endsequence

  chk_b_answer: assert property (s_wr_take |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
  chk_wr_block: assert property (s_axi_bvalid
    |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid)
    else $error("read data late");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  chk_unmapped_rd: assert property (s_axi_arvalid && s_axi_arready
    && s_axi_araddr >= 8'h38 |=> s_axi_rresp == 2'b10
    && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  chk_status_pad: assert property (s_rd_take(OFF_STATUS)
    |=> s_axi_rdata[31:16] == 16'h0 && s_axi_rdata[12:7] == 6'h0)
    else $error("unused status bits set");
  chk_pin_level: assert property (
    s_rd_take(OFF_STATUS) and s_pins_quiet
    |=> s_axi_rdata[13] || s_axi_rdata[6:4] == $past(pin_lvl))
    else $error("status pin bits wrong");
endmodule // ecs_checker

bind ecs_top ecs_checker #(.ZF_CYC(ZF_CYC)) i_chk (
  .ref_clk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pins);

// [ecs_host.sv]
// bus master model standing in for the controller side
`timescale 1ns/1ps
module ecs_host (
  // clock
  input  wire logic   ref_clk,
  // write channels
  output logic [7:0]  s_axi_awaddr = 8'h00,
  output logic        s_axi_awvalid = 1'b0,
  input  wire logic   s_axi_awready,
  output logic [31:0] s_axi_wdata = 32'h0,
  output logic [3:0]  s_axi_wstrb = 4'hF,
  output logic        s_axi_wvalid = 1'b0,
  input  wire logic   s_axi_wready,
  input  wire logic [1:0] s_axi_bresp,
  input  wire logic   s_axi_bvalid,
  output logic        s_axi_bready = 1'b0,
  // read channels
  output logic [7:0]  s_axi_araddr = 8'h00,
  output logic        s_axi_arvalid = 1'b0,
  input  wire logic   s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0] s_axi_rresp,
  input  wire logic   s_axi_rvalid,
  output logic        s_axi_rready = 1'b0
);
  logic slow = 1'b0;  // late ready, so answers must be held

  // one write; address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    @(posedge ref_clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= !slow;
    fork
      begin
        do @(posedge ref_clk); while (!s_axi_awready);
        s_axi_awvalid <= 1'b0;
      end
      begin
        do @(posedge ref_clk); while (!s_axi_wready);
        s_axi_wvalid <= 1'b0;
      end
    join
    if (slow) begin
      repeat (3) @(posedge ref_clk);
      s_axi_bready <= 1'b1;
    end
    do @(posedge ref_clk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  // one read; data taken at the handshake edge
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge ref_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= !slow;
    do @(posedge ref_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    if (slow) begin
      repeat (3) @(posedge ref_clk);
      s_axi_rready <= 1'b1;
    end
    do @(posedge ref_clk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule // ecs_host

// [ecs_tb.sv]
// self-checking bench for the counter status block
`timescale 1ns/1ps
module tb import ecs_pkg::*;;
  localparam int unsigned ZF = 50;  // short zero-frequency wait
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  ecs_pins_t   pins = '0;
  logic        irq;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  int          bad_count = 0;
  int          tests_run = 0;
  // {offset, data, expected error word}, applied in order
  localparam logic [50:0] ROWS [20] = '{
    {OFF_CFG1, 32'h01000000, 11'h400},
    {OFF_CFG1, 32'h00000BC2, 11'h004},
    {OFF_CFG1, 32'h0000000F, 11'h004},
    {OFF_CFG1, 32'h0000000A, 11'h000},
    {OFF_CFG0, 32'h00007300, 11'h002},
    {OFF_CFG0, 32'h00007000, 11'h002},
    {OFF_CFG0, 32'h00000007, 11'h008},
    {OFF_CFG0, 32'hC9000007, 11'h008},
    {OFF_CFG0, 32'hC8FC0007, 11'h000},
    {OFF_CFG0, 32'hC8FB0007, 11'h200},
    {OFF_CFG0, 32'h00007805, 11'h040},
    {OFF_CFG1, 32'h0080000A, 11'h000},
    {OFF_CFG0, 32'h00007803, 11'h001},
    {OFF_CFG0, 32'h00007850, 11'h001},
    {OFF_CFG0, 32'h00007800, 11'h000},
    {OFF_ROLLOVER, 32'h0, 11'h030},
    {OFF_ROLLOVER, 32'h01000001, 11'h010},
    {OFF_ROLLOVER, 32'h01000000, 11'h000},
    {OFF_PRESET, 32'h01000000, 11'h020},
    {OFF_PRESET, 32'h0, 11'h000}};

  ecs_host i_host (.*);
  ecs_top #(.ZF_CYC(ZF)) i_dut (.*);

  // free-running 50 MHz clock
  initial begin
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // masked read compare
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, e);
    i_host.rd(a, rv, rr);
    check(rv & m, e);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_host.wr(a, d, rr);
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // pins high long enough to pass the synchronisers, then low
  task automatic pulse(input logic [3:0] p);
    pins <= p;
    step(5);
    pins <= '0;
    step(5);
  endtask

  task automatic summarize;
    $display("checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // hang guard, far beyond the 1100 or so cycles needed
  initial begin
    #400000;
    bad_count++;
    summarize();
  end

  initial begin
    step(8);
    rst <= 1'b0;
    i_host.slow = 1'b1;
    rdc(OFF_STATUS, 32'h2000, 32'h2000);
    rdc(OFF_CFG0, '1, CFG0_RST);
    rdc(OFF_ROLLOVER, '1, ROLLOVER_RST);
    rdc(OFF_ERRCODE, '1, 32'h0);
    wr(OFF_SNAP, 32'h0);
    i_host.slow = 1'b0;
    rdc(OFF_SNAP, '1, 32'h0);
    step(600);
    rdc(OFF_STATUS, '1, 32'h0002);
    $display("reset test done");
    for (int i = 0; i < 8; i++) begin
      pins <= 4'(i);
      step(5);
      rdc(OFF_STATUS, 32'h72, {25'h0, 3'(i), 2'h0, i == 0, 1'h0});
    end
    pins <= '0;
    rdc(OFF_LIVE, '1, 32'h4);
    $display("pin test done");
    wr(OFF_PRESET, 32'h00FFFFFE);
    wr(OFF_SNAP, 32'h2);
    wr(OFF_SNAP, 32'h0);
    rdc(OFF_LIVE, '1, 32'h00FFFFFE);
    wr(OFF_CFG0, 32'h00007810);
    pulse(4'h4);
    pulse(4'h4);
    rdc(OFF_CAPT, '1, 32'h00FFFFFE);
    rdc(OFF_STATUS, 32'hC, 32'h8);
    wr(OFF_SNAP, 32'h1);
    wr(OFF_SNAP, 32'h4);
    wr(OFF_SNAP, 32'h0);
    rdc(OFF_LIVE, '1, 32'h0);
    rdc(OFF_CAPT, '1, 32'h0);
    wr(OFF_CFG0, CFG0_RST);
    wr(OFF_LIVE, 32'h5);
    check({30'h0, rr}, 32'h2);
    $display("snapshot test done");
    foreach (ROWS[k]) begin
      wr(ROWS[k][50:43], ROWS[k][42:11]);
      step(2);
      rdc(OFF_ERRCODE, '1, {21'h0, ROWS[k][10:0]});
      rdc(OFF_STATUS, 32'h8000, {16'h0, |ROWS[k][10:0], 15'h0});
    end
    wr(OFF_OUTCFG, 32'h1);
    rdc(OFF_ERRCODE, '1, 32'h010);
    wr(OFF_OUTCFG, 32'h2);
    rdc(OFF_ERRCODE, '1, 32'h080);
    wr(OFF_WIN_ON, 32'h5);
    wr(OFF_WIN_OFF, 32'h5);
    rdc(OFF_ERRCODE, '1, 32'h100);
    wr(OFF_WIN_OFF, 32'h02000000);
    rdc(OFF_ERRCODE, '1, 32'h100);
    wr(OFF_WIN_OFF, 32'h0);
    $display("config test done");
    wr(OFF_CFG1, 32'h01000000);
    pulse(4'h1);
    rdc(OFF_LIVE, '1, 32'h0);
    rdc(OFF_IRQ_STAT, 32'h2, 32'h2);
    check({31'h0, irq}, 32'h0);
    wr(OFF_IRQ_MASK, 32'h2);
    step(2);
    #1;
    check({31'h0, irq}, 32'h1);
    wr(OFF_IRQ_STAT, 32'h2);
    step(2);
    #1;
    check({31'h0, irq}, 32'h0);
    rdc(8'h38, '1, 32'h0);
    pulse(4'h8);
    rdc(OFF_STATUS, 32'h4000, 32'h4000);
    $display("fault test done");
    summarize();
  end
endmodule // tb
